// ===== pkg/snr_map.svh
/*
  Opcodes, feature addresses, field positions, column limits and phase
  lengths of the serial NAND command block.
  Assumes the includer uses these only as sized constants.
*/
`ifndef SNR_MAP_SVH
`define SNR_MAP_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SNR_OP_LATCH_SET 8'h06
`define SNR_OP_LATCH_CLEAR 8'h04
`define SNR_OP_GET_FEAT 8'h0f
`define SNR_OP_PAGE_READ 8'h13
`define SNR_OP_READ 8'h03
`define SNR_OP_READ_FAST 8'h0b
`define SNR_OP_READ_X2 8'h3b
`define SNR_OP_READ_X4 8'h6b
`define SNR_OP_READ_DIO 8'hbb
`define SNR_OP_READ_QIO 8'heb
`define SNR_OP_READ_DTR 8'hee
`define SNR_OP_READ_ID 8'h9f
`define SNR_OP_RESET 8'hff
`define SNR_OP_PROG_EXEC 8'h10
`define SNR_OP_ERASE 8'hd8

// ----------------------------------------------------------------------
// Feature addresses and bit positions
// ----------------------------------------------------------------------
`define SNR_FEAT_CFG 8'hb0
`define SNR_FEAT_STATUS 8'hc0
`define SNR_CFG_QE_BIT 0
`define SNR_CFG_ECC_BIT 4
`define SNR_CFG_OTP_BIT 6
`define SNR_STS_BUSY_BIT 0
`define SNR_STS_WEL_BIT 1

// ----------------------------------------------------------------------
// Column layout
// ----------------------------------------------------------------------
`define SNR_COL_MAIN 12'h800
`define SNR_COL_SPARE 12'h040
`define SNR_COL_ECC 12'h040
`define SNR_UID_SPAN 12'h200

// ----------------------------------------------------------------------
// Phase lengths, in edges for address and in clocks for dummy
// ----------------------------------------------------------------------
`define SNR_OPCODE_LAST 5'd7
`define SNR_EDGES_COL 5'd16
`define SNR_EDGES_COL_DIO 5'd8
`define SNR_EDGES_COL_QIO 5'd4
`define SNR_EDGES_COL_DTR 5'd8
`define SNR_EDGES_FEAT 5'd8
`define SNR_EDGES_ROW 5'd24
`define SNR_DUMMY_STD 4'd8
`define SNR_DUMMY_DIO 4'd4
`define SNR_DUMMY_QIO 4'd4
`define SNR_DUMMY_DTR 4'd8
`define SNR_DUMMY_ID 4'd8

`endif

// ===== pkg/snr_pkg.sv
/*
  Types shared by the serial NAND command block.
  Assumes snr_map.svh supplies all numeric constants.
*/
package snr_pkg;

  typedef enum logic [2:0] {
    SNR_IDLE,
    SNR_ADDR,
    SNR_DUMMY,
    SNR_DATA,
    SNR_SKIP
  } snr_state_e;

  typedef enum logic [1:0] {
    SNR_SRC_NONE,
    SNR_SRC_CACHE,
    SNR_SRC_FEAT,
    SNR_SRC_ID
  } snr_src_e;

  typedef struct packed {
    logic [4:0] addr_edges;
    logic [3:0] dummy;
    logic [2:0] in_lanes;
    logic [2:0] out_lanes;
    logic dtr;
    logic quad_only;
    snr_src_e src;
  } snr_cmd_s;

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic [3:0] io_m;
    logic [3:0] io_s;
    snr_state_e st;
    logic [7:0] op;
    logic [31:0] sh;
    logic [4:0] cnt;
    logic [11:0] col;
    logic [11:0] cache_addr;
    logic [7:0] feat_addr;
    logic fetch_on;
    logic fetch_pend;
    logic [7:0] out_sh;
    logic [3:0] out_left;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic write_enable_latch;
    logic busy;
    logic uid_mode;
    logic array_load;
    logic array_alter;
    logic array_erase;
    logic array_abort;
    logic [23:0] array_addr;
  } snr_reg_s;

endpackage

// ===== src/snr_byte_buffer.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock domain; i_clear empties it and wins over a push.
*/
`timescale 1ns/1ps
module snr_byte_buffer #(
  parameter int W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wr;
    logic rd;
    logic [1:0] count;
  } snr_buf_s;

  snr_buf_s r;
  snr_buf_s n;
  logic do_push;
  logic do_pop;

  assign o_ready = (r.count != 2'd2);
  assign o_valid = (r.count != 2'd0);
  assign o_data = r.mem[r.rd];

  always_comb
  begin
    n = r;
    do_push = i_valid && o_ready;
    do_pop = i_ready && o_valid;
    if (do_push)
    begin
      n.mem[r.wr] = i_data;
      n.wr = ~r.wr;
    end
    if (do_pop)
    begin
      n.rd = ~r.rd;
    end
    if (do_push && !do_pop)
    begin
      n.count = r.count + 2'd1;
    end
    else if (do_pop && !do_push)
    begin
      n.count = r.count - 2'd1;
    end
    if (i_clear)
    begin
      n.wr = 1'b0;
      n.rd = 1'b0;
      n.count = 2'd0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

endmodule

// ===== src/snr_nand_cmd.sv
/*
  Serial NAND command logic: write-enable latch, page read to cache,
  cache reads in x1, x2, x4, dual, quad and quad DTR, ID and serial number.
  Assumes the host's serial clock is far slower than i_clk_sys (at least
  eight system clocks per serial clock) and that cache, array and feature
  inputs live on i_clk_sys.
*/
// Functional notes
// - Latch-set opcode sets the write-enable latch.
// - Reset command clears the write-enable latch.
// - Latch-clear opcode clears the write-enable latch.
// - Program or erase start clears the write-enable latch.
// - Page read takes 24 address bits, loads array page, busy until done.
// - Get-features is accepted while busy so status can be polled.
// - Cache output starts at given column and wraps at page section end.
// - x4, quad-address and quad DTR reads need quad enable set.
// - Quad enable is bit 0 of feature register B0.
// - With ECC on, read continues through 64 extra ECC bytes before wrap.
// - Dual read takes 4 dummy bits, 12 column bits, 4 dummy clocks, x2.
// - Dual read shifts data out two bits per clock on lines 0 and 1.
// - Quad read takes address and dummy over four lines, data four bits.
// - Dual and quad reads increment the column after every byte.
// - Quad DTR moves address and data on both serial clock edges.
// - Quad DTR address rolls over to zero after the highest column.
// - ID opcode returns maker code then part code, MSB first.
// - Serial number in bytes 0 to 15, complement in 16 to 31.
// - Sixteen copies of the serial number pair, 32 bytes each.
// - Reset aborts array work and clears latch and busy.
// - Single, x2 and x4 reads take one dummy byte of 8 clocks.
// - Their 16-clock column phase holds 4 dummy then 12 address bits.
`timescale 1ns/1ps
`include "snr_map.svh"
module snr_nand_cmd #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] PART_CODE = 8'h3c,
  parameter logic [127:0] UNIQUE_SERIAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io,
  input wire logic i_quad_io_enable,
  input wire logic i_ecc_enable,
  input wire logic i_otp_enable,
  input wire logic [7:0] i_cache_data,
  input wire logic i_array_done,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  output logic [11:0] o_cache_addr,
  output logic o_array_load,
  output logic o_array_alter,
  output logic o_array_erase,
  output logic o_array_abort,
  output logic [23:0] o_array_addr,
  output logic o_busy,
  output logic o_write_enable_latch
);
  // The identity codes and serial number defaults above are arbitrary.

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic snr_pkg::snr_cmd_s decode(input logic [7:0] op);
    snr_pkg::snr_cmd_s c;
    c = '0;
    c.in_lanes = 3'd1;
    c.out_lanes = 3'd1;
    case (op)
      `SNR_OP_READ, `SNR_OP_READ_FAST, `SNR_OP_READ_X2, `SNR_OP_READ_X4:
      begin
        c.addr_edges = `SNR_EDGES_COL;
        c.dummy = `SNR_DUMMY_STD;
        c.src = snr_pkg::SNR_SRC_CACHE;
        c.out_lanes = (op == `SNR_OP_READ_X2) ? 3'd2 :
                      (op == `SNR_OP_READ_X4) ? 3'd4 : 3'd1;
        c.quad_only = (op == `SNR_OP_READ_X4);
      end
      `SNR_OP_READ_DIO:
      begin
        c.addr_edges = `SNR_EDGES_COL_DIO;
        c.dummy = `SNR_DUMMY_DIO;
        c.in_lanes = 3'd2;
        c.out_lanes = 3'd2;
        c.src = snr_pkg::SNR_SRC_CACHE;
      end
      `SNR_OP_READ_QIO:
      begin
        c.addr_edges = `SNR_EDGES_COL_QIO;
        c.dummy = `SNR_DUMMY_QIO;
        c.in_lanes = 3'd4;
        c.out_lanes = 3'd4;
        c.quad_only = 1'b1;
        c.src = snr_pkg::SNR_SRC_CACHE;
      end
      `SNR_OP_READ_DTR:
      begin
        c.addr_edges = `SNR_EDGES_COL_DTR;
        c.dummy = `SNR_DUMMY_DTR;
        c.in_lanes = 3'd4;
        c.out_lanes = 3'd4;
        c.dtr = 1'b1;
        c.quad_only = 1'b1;
        c.src = snr_pkg::SNR_SRC_CACHE;
      end
      `SNR_OP_GET_FEAT:
      begin
        c.addr_edges = `SNR_EDGES_FEAT;
        c.src = snr_pkg::SNR_SRC_FEAT;
      end
      `SNR_OP_READ_ID:
      begin
        c.dummy = `SNR_DUMMY_ID;
        c.src = snr_pkg::SNR_SRC_ID;
      end
      `SNR_OP_PAGE_READ, `SNR_OP_PROG_EXEC, `SNR_OP_ERASE:
      begin
        c.addr_edges = `SNR_EDGES_ROW;
      end
      default:
      begin
        c.src = snr_pkg::SNR_SRC_NONE;
      end
    endcase
    return c;
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] io,
                                           input logic [2:0] w);
    case (w)
      3'd1: return {sh[30:0], io[0]};
      3'd2: return {sh[29:0], io[1:0]};
      default: return {sh[27:0], io[3:0]};
    endcase
  endfunction

  // Single-lane data leaves on line 1; wider modes use the low lines first.
  function automatic logic [3:0] lanes_out(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'd1: return {2'b00, b[7], 1'b0};
      3'd2: return {2'b00, b[7:6]};
      default: return b[7:4];
    endcase
  endfunction

  function automatic logic [3:0] lanes_oe(input logic [2:0] w);
    case (w)
      3'd1: return 4'b0010;
      3'd2: return 4'b0011;
      default: return 4'b1111;
    endcase
  endfunction

  function automatic logic [11:0] col_next(input logic [11:0] col, input logic ecc);
    logic [11:0] last;
    last = `SNR_COL_MAIN + `SNR_COL_SPARE;
    if (ecc)
    begin
      last = last + `SNR_COL_ECC;
    end
    if (col + 12'd1 >= last)
    begin
      return 12'd0;
    end
    return col + 12'd1;
  endfunction

  function automatic logic [7:0] uid_byte(input logic [11:0] a);
    logic [127:0] sn;
    sn = UNIQUE_SERIAL >> {~a[3:0], 3'b000};
    if (a >= `SNR_UID_SPAN)
    begin
      return 8'h00;
    end
    return a[4] ? ~sn[7:0] : sn[7:0];
  endfunction

  function automatic logic [7:0] feat_byte(input logic [7:0] fa, input logic qe,
                                           input logic ecc, input logic otp,
                                           input logic write_enable_latch, input logic busy);
    logic [7:0] b;
    b = 8'h00;
    if (fa == `SNR_FEAT_CFG)
    begin
      b[`SNR_CFG_QE_BIT] = qe;
      b[`SNR_CFG_ECC_BIT] = ecc;
      b[`SNR_CFG_OTP_BIT] = otp;
    end
    else if (fa == `SNR_FEAT_STATUS)
    begin
      b[`SNR_STS_BUSY_BIT] = busy;
      b[`SNR_STS_WEL_BIT] = write_enable_latch;
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  snr_pkg::snr_reg_s r;
  snr_pkg::snr_reg_s n;
  snr_pkg::snr_cmd_s cmd;
  snr_pkg::snr_cmd_s nc;
  logic rise;
  logic fall;
  logic in_edge;
  logic out_edge;
  logic push;
  logic pop;
  logic buf_ready;
  logic buf_valid;
  logic [7:0] push_data;
  logic [7:0] buf_data;
  logic [31:0] sh_next;
  logic [23:0] row;
  logic [7:0] op_next;

  snr_byte_buffer #(
    .W(8)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clear(r.cs_s),
    .i_valid(push),
    .o_ready(buf_ready),
    .i_data(push_data),
    .o_valid(buf_valid),
    .i_ready(pop),
    .o_data(buf_data)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.sclk_m = i_sclk;
    n.sclk_s = r.sclk_m;
    n.sclk_d = r.sclk_s;
    n.cs_m = i_cs_n;
    n.cs_s = r.cs_m;
    n.io_m = i_io;
    n.io_s = r.io_m;
    n.array_load = 1'b0;
    n.array_alter = 1'b0;
    n.array_abort = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    cmd = decode(r.op);
    rise = r.sclk_s & ~r.sclk_d;
    fall = ~r.sclk_s & r.sclk_d;
    // The falling edge that closes the opcode clock carries no address nibble.
    in_edge = rise | (fall & cmd.dtr & (r.st == snr_pkg::SNR_ADDR) &
                      (r.cnt != cmd.addr_edges));
    out_edge = fall | (rise & cmd.dtr);
    sh_next = shift_in(r.sh, r.io_s, (r.st == snr_pkg::SNR_IDLE) ? 3'd1 : cmd.in_lanes);
    op_next = sh_next[7:0];
    nc = decode(op_next);
    row = sh_next[23:0];
    if (i_array_done)
    begin
      n.busy = 1'b0;
    end
    case (cmd.src)
      snr_pkg::SNR_SRC_CACHE: push_data = r.uid_mode ? uid_byte(r.cache_addr) : i_cache_data;
      snr_pkg::SNR_SRC_FEAT: push_data = feat_byte(r.feat_addr, i_quad_io_enable,
                                                   i_ecc_enable, i_otp_enable, r.write_enable_latch, r.busy);
      snr_pkg::SNR_SRC_ID: push_data = r.cache_addr[0] ? PART_CODE : MAKER_CODE;
      default: push_data = 8'h00;
    endcase
    // Only one fetch is ever in flight, so a free slot at issue is still free at push.
    if (r.fetch_pend)
    begin
      push = 1'b1;
      n.fetch_pend = 1'b0;
    end
    else if (r.fetch_on && buf_ready)
    begin
      n.fetch_pend = 1'b1;
      n.cache_addr = r.col;
      n.col = col_next(r.col, i_ecc_enable);
    end
    case (r.st)
      snr_pkg::SNR_IDLE:
      begin
        if (rise)
        begin
          n.sh = sh_next;
          n.cnt = r.cnt + 5'd1;
          if (r.cnt == `SNR_OPCODE_LAST)
          begin
            n.op = op_next;
            n.cnt = 5'd0;
            n.st = snr_pkg::SNR_SKIP;
            if (r.busy && op_next != `SNR_OP_GET_FEAT && op_next != `SNR_OP_RESET)
            begin
              n.st = snr_pkg::SNR_SKIP;
            end
            else if (nc.quad_only && !i_quad_io_enable)
            begin
              n.st = snr_pkg::SNR_SKIP;
            end
            else if (op_next == `SNR_OP_LATCH_SET)
            begin
              n.write_enable_latch = 1'b1;
            end
            else if (op_next == `SNR_OP_LATCH_CLEAR)
            begin
              n.write_enable_latch = 1'b0;
            end
            else if (op_next == `SNR_OP_RESET)
            begin
              n.write_enable_latch = 1'b0;
              n.busy = 1'b0;
              n.array_abort = r.busy;
            end
            else if (nc.addr_edges != 5'd0)
            begin
              n.st = snr_pkg::SNR_ADDR;
              n.cnt = nc.addr_edges;
            end
            else if (nc.dummy != 4'd0)
            begin
              n.st = snr_pkg::SNR_DUMMY;
              n.cnt = {1'b0, nc.dummy};
              n.col = 12'd0;
              n.fetch_on = 1'b1;
            end
          end
        end
      end
      snr_pkg::SNR_ADDR:
      begin
        if (in_edge)
        begin
          n.sh = sh_next;
          n.cnt = r.cnt - 5'd1;
          if (r.cnt == 5'd1)
          begin
            n.col = sh_next[11:0];
            n.feat_addr = sh_next[7:0];
            n.st = snr_pkg::SNR_SKIP;
            if (r.op == `SNR_OP_PAGE_READ)
            begin
              n.busy = 1'b1;
              n.array_load = 1'b1;
              n.array_addr = row;
              n.uid_mode = i_otp_enable && (row == 24'h000000);
            end
            else if (r.op == `SNR_OP_PROG_EXEC || r.op == `SNR_OP_ERASE)
            begin
              if (r.write_enable_latch)
              begin
                n.array_alter = 1'b1;
                n.array_erase = (r.op == `SNR_OP_ERASE);
                n.array_addr = row;
                n.busy = 1'b1;
                n.write_enable_latch = 1'b0;
              end
            end
            else if (cmd.dummy != 4'd0)
            begin
              n.st = snr_pkg::SNR_DUMMY;
              n.cnt = {1'b0, cmd.dummy};
              n.fetch_on = 1'b1;
            end
            else
            begin
              n.st = snr_pkg::SNR_DATA;
              n.fetch_on = 1'b1;
            end
          end
        end
      end
      snr_pkg::SNR_DUMMY:
      begin
        if (rise)
        begin
          n.cnt = r.cnt - 5'd1;
          if (r.cnt == 5'd1)
          begin
            n.st = snr_pkg::SNR_DATA;
          end
        end
      end
      snr_pkg::SNR_DATA:
      begin
        if (out_edge)
        begin
          if (r.out_left == 4'd0)
          begin
            if (buf_valid)
            begin
              pop = 1'b1;
              n.io_out = lanes_out(buf_data, cmd.out_lanes);
              n.io_oe = lanes_oe(cmd.out_lanes);
              n.out_sh = buf_data << cmd.out_lanes;
              n.out_left = 4'd8 - {1'b0, cmd.out_lanes};
            end
          end
          else
          begin
            n.io_out = lanes_out(r.out_sh, cmd.out_lanes);
            n.out_sh = r.out_sh << cmd.out_lanes;
            n.out_left = r.out_left - {1'b0, cmd.out_lanes};
          end
        end
      end
      default:
      begin
        n.st = r.st;
      end
    endcase
    // Chip select high ends any transfer; the buffer is flushed with it.
    if (r.cs_s)
    begin
      n.st = snr_pkg::SNR_IDLE;
      n.cnt = 5'd0;
      n.fetch_on = 1'b0;
      n.fetch_pend = 1'b0;
      n.io_oe = 4'b0000;
      n.out_left = 4'd0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_io_out = r.io_out;
  assign o_io_oe = r.io_oe;
  assign o_cache_addr = r.cache_addr;
  assign o_array_load = r.array_load;
  assign o_array_alter = r.array_alter;
  assign o_array_erase = r.array_erase;
  assign o_array_abort = r.array_abort;
  assign o_array_addr = r.array_addr;
  assign o_busy = r.busy;
  assign o_write_enable_latch = r.write_enable_latch;

endmodule

// ===== tb/snr_nand_cmd_props.sv
/*
  Checker for the serial NAND command block, bound to its top module.
  Assumes it sees only top ports, all on the system clock.
*/
`timescale 1ns/1ps
module snr_nand_cmd_props (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_quad_io_enable,
  input wire logic i_array_done,
  input wire logic [3:0] o_io_oe,
  input wire logic o_array_load,
  input wire logic o_array_alter,
  input wire logic o_array_abort,
  input wire logic o_busy,
  input wire logic o_write_enable_latch
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  property p_alter_needs_latch;
    o_array_alter |-> $past(o_write_enable_latch);
  endproperty
  a_alter_needs_latch: assert property (p_alter_needs_latch) else $error("alter, latch clear");
  property p_alter_clears;
    o_array_alter |=> !o_write_enable_latch;
  endproperty
  a_alter_clears: assert property (p_alter_clears) else $error("latch kept after alter");
  property p_load_busy;
    o_array_load && !i_array_done |=> o_busy;
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("no busy after load");
  property p_busy_holds;
    o_busy && !i_array_done && !o_array_abort |=> o_busy || o_array_abort;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");
  property p_done_clears;
    o_busy && i_array_done |=> !o_busy || o_array_load || o_array_alter;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("busy kept after done");
  property p_busy_refuses;
    $past(o_busy) && o_busy |-> !o_array_load && !o_array_alter;
  endproperty
  a_busy_refuses: assert property (p_busy_refuses) else $error("array start while busy");
  property p_abort_clears;
    o_array_abort |=> !o_busy && !o_write_enable_latch;
  endproperty
  a_abort_clears: assert property (p_abort_clears) else $error("reset left state");
  property p_quad_gate;
    o_io_oe[3] |-> i_quad_io_enable;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad drive, quad off");
  property p_idle_release;
    i_cs_n [*8] |-> o_io_oe == 4'h0;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("pins driven, deselected");
  property p_latch_in_frame;
    $rose(o_write_enable_latch) |-> $past(i_cs_n, 6) == 1'b0 && !o_busy;
  endproperty
  a_latch_in_frame: assert property (p_latch_in_frame) else $error("latch set off frame");
  c_load: cover property (o_array_load);
  c_abort: cover property (o_array_abort);
  c_quad: cover property (o_io_oe == 4'hf);
endmodule
bind snr_nand_cmd snr_nand_cmd_props u_props (.*);

// ===== tb/snr_host_model.sv
/*
  Host flash controller model: mode 0 serial clock, chip select, io lines.
  Assumes the bench resolves the io pins from the device's output enables alone.
*/
`timescale 1ns/1ps
module snr_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io,
  input wire logic [3:0] i_pins
);
  event got;
  logic [7:0] rd;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  // --------------------------------------------------------------------
  // One serial clock; sampled late in the high phase for margin.
  // --------------------------------------------------------------------
  task cyc(input logic [3:0] a, output logic [3:0] q);
    #60 o_io <= a;
    #100 o_sclk <= 1'b1;
    #120 q = i_pins;
    #40 o_sclk <= 1'b0;
  endtask
  task xfer(input logic [7:0] op, input logic [31:0] ad, input int an, input int ln,
            input int dm, input int nb, input int ol);
    logic [3:0] q;
    logic [7:0] b;
    int i;
    int k;
    o_cs_n <= 1'b0;
    for (i = 7; i >= 0; i--)
      cyc({3'b0, op[i]}, q);
    for (i = an - ln; i >= 0; i -= ln)
      cyc(4'(ad >> i) & 4'((1 << ln) - 1), q);
    for (i = 0; i < dm; i++)
      cyc(~o_io, q);
    for (k = 0; k < nb; k++)
    begin
      for (i = 0; i < 8; i += ol)
      begin
        cyc(~o_io, q);
        q = (ol == 1) ? q >> 1 : q;
        b = 8'((b << ol) | (q & 4'((1 << ol) - 1)));
      end
      rd = b;
      -> got;
    end
    #100 o_cs_n <= 1'b1;
    #400;
  endtask
  // Double-rate quad read: address nibbles on both edges, data nibble per edge.
  task xdtr(input logic [11:0] c, input int nb);
    logic [3:0] q;
    logic [31:0] ad;
    logic [7:0] op;
    int i;
    ad = {20'h0, c};
    op = 8'hee;
    o_cs_n <= 1'b0;
    for (i = 7; i >= 0; i--)
      cyc({3'b0, op[i]}, q);
    for (i = 7; i >= 0; i--)
    begin
      #80 o_io <= 4'(ad >> (4 * i));
      #80 o_sclk <= ~o_sclk;
    end
    for (i = 0; i < 8; i++)
      cyc(4'h0, q);
    #40;
    for (i = 0; i < nb; i++)
    begin
      #120 o_sclk <= 1'b1;
      #40 q = i_pins;
      #120 o_sclk <= 1'b0;
      #40 rd = {q, i_pins};
      -> got;
    end
    #100 o_cs_n <= 1'b1;
    #400;
  endtask
endmodule

// ===== tb/snr_nand_cmd_tb.sv
/*
  Self-checking bench for the serial NAND command block.
  Assumes a combinational cache model and manual array completion pulses.
*/
`timescale 1ns/1ps
module snr_nand_cmd_tb;
  localparam logic [7:0] MAKER = 8'h3e; // Arbitrary value.
  localparam logic [7:0] PART = 8'hd1; // Arbitrary value.
  localparam logic [127:0] SER = 128'h1f2e_3d4c_5b6a_7988_0112_2334_4556_6778;
  logic i_clk_sys, i_rst_n, i_sclk, i_cs_n, i_quad_io_enable, i_ecc_enable, i_otp_enable;
  logic i_array_done, o_array_load, o_array_alter, o_array_erase, o_array_abort;
  logic o_busy, o_write_enable_latch;
  logic [3:0] i_io, o_io_out, o_io_oe, hio;
  logic [7:0] i_cache_data;
  logic [11:0] o_cache_addr, col;
  logic [23:0] o_array_addr;
  logic [7:0] exp[$];
  int n_errors, check_count, n;
  snr_nand_cmd #(.MAKER_CODE(MAKER), .PART_CODE(PART), .UNIQUE_SERIAL(SER)) dut (.*);
  snr_host_model h (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_io(hio), .i_pins(i_io));
  assign i_io = (o_io_oe & o_io_out) | (~o_io_oe & hio);
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [7:0] cv(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  assign i_cache_data = cv(o_cache_addr);
  // --------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      n_errors++;
      $display("BAD rd_byte expected %h seen %h", want, seen);
    end
  endtask
  always @(h.got) check(h.rd, exp.size() != 0 ? exp.pop_front() : 8'hxx);
  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #3000000 n_errors++;
    finish_test;
  end
  // --------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------
  task cmd(input logic [7:0] op, input logic [31:0] ad, input int an);
    h.xfer(op, ad, an, 1, 0, 0, 1);
  endtask
  task st(input logic [7:0] e);
    exp.push_back(e);
    h.xfer(8'h0f, 32'hc0, 8, 1, 0, 1, 1);
  endtask
  task rc(input logic [7:0] op, input logic [11:0] c, input int ln, input int dm,
          input int ol, input int nb, input int wrap);
    for (int i = 0; i < nb; i++)
      exp.push_back(cv(12'((c + i) % wrap)));
    h.xfer(op, {20'h0, c}, 16, ln, dm, nb, ol);
  endtask
  task done;
    @(posedge i_clk_sys) i_array_done <= 1'b1;
    @(posedge i_clk_sys) i_array_done <= 1'b0;
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    {i_quad_io_enable, i_ecc_enable, i_otp_enable, i_array_done} = 4'h0;
    n_errors = 0;
    check_count = 0;
    void'($urandom(32'h2a78));
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    st(8'h00);
    cmd(8'h06, 0, 0);
    st(8'h02);
    cmd(8'h04, 0, 0);
    st(8'h00);
    cmd(8'hd8, 32'h40, 24);
    st(8'h00);
    cmd(8'h06, 0, 0);
    cmd(8'h10, 32'h41, 24);
    st(8'h01);
    done;
    st(8'h00);
    cmd(8'h06, 0, 0);
    cmd(8'h13, 32'h123, 24);
    st(8'h03);
    cmd(8'hff, 0, 0);
    st(8'h00);
    cmd(8'h13, 32'h7, 24);
    done;
    st(8'h00);
    rc(8'h03, 12'd2110, 1, 8, 1, 4, 2112);
    @(posedge i_clk_sys) i_ecc_enable <= 1'b1;
    rc(8'h0b, 12'd2174, 1, 8, 1, 3, 2176);
    @(posedge i_clk_sys) i_ecc_enable <= 1'b0;
    col = 12'($urandom_range(2047));
    rc(8'h3b, col, 1, 8, 2, 2, 2112);
    h.xfer(8'h6b, 0, 16, 1, 8, 0, 4);
    @(posedge i_clk_sys) i_quad_io_enable <= 1'b1;
    rc(8'h6b, col, 1, 8, 4, 2, 2112);
    rc(8'hbb, col, 2, 4, 2, 3, 2112);
    rc(8'heb, col, 4, 4, 4, 3, 2112);
    for (n = 2110; n < 2113; n++)
      exp.push_back(cv(12'(n % 2112)));
    h.xdtr(12'd2110, 3);
    @(posedge i_clk_sys) i_quad_io_enable <= 1'b0;
    exp.push_back(MAKER);
    exp.push_back(PART);
    h.xfer(8'h9f, 0, 0, 1, 8, 2, 1);
    @(posedge i_clk_sys) i_otp_enable <= 1'b1;
    cmd(8'h13, 32'h0, 24);
    done;
    for (n = 30; n < 34; n++)
      exp.push_back((n % 32 < 16) ? SER[127 - 8 * (n % 16) -: 8] : ~SER[127 - 8 * (n % 16) -: 8]);
    h.xfer(8'h03, 32'd30, 16, 1, 8, 4, 1);
    finish_test;
  end
endmodule
